// File: sdb_params.svh
`ifndef SDB_PARAMS_SVH
`define SDB_PARAMS_SVH

// ----------------------------------------
// Register indexes on the plain port
// ----------------------------------------
`define SDB_OFS_RX_BUF      3'h0
`define SDB_OFS_TX_BUF      3'h1
`define SDB_OFS_DIV_LOW     3'h2
`define SDB_OFS_DIV_HIGH    3'h3
`define SDB_OFS_CTRL        3'h4
`define SDB_OFS_STATUS      3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDB_CTRL_SYNC       0
`define SDB_CTRL_FAST       1
`define SDB_CTRL_WIDE       2
`define SDB_CTRL_TX9        3
`define SDB_STAT_RX9        0
`define SDB_STAT_RX_FULL    1
`define SDB_STAT_TX_FULL    2
`define SDB_STAT_FIFO_DATA  3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDB_RST_BYTE        8'h00
`define SDB_RST_CTRL        4'h0

// ----------------------------------------
// Prescale counts per rate formula
// ----------------------------------------
`define SDB_PRESC_SLOW      7'h40
`define SDB_PRESC_FAST      7'h10
`define SDB_PRESC_SYNC      7'h04

`endif

// File: sdb_pkg.sv
package sdb_pkg;
   typedef logic [2:0]  sdb_addr_t;   // Register index
   typedef logic [7:0]  sdb_byte_t;   // Register data

   // All state of the top module
   typedef struct packed {
      logic [7:0]  rd_data;
      logic [7:0]  rx_byte;
      logic        rx_ninth;
      logic        rx_full;
      logic [7:0]  tx_last;
      logic [7:0]  tx_data;
      logic        tx_ninth;
      logic        tx_valid;
      logic        tx9_stage;
      logic [7:0]  div_low;
      logic [7:0]  div_high;
      logic        sync_mode;
      logic        fast_rate;
      logic        wide_div;
      logic [6:0]  pre_cnt;
      logic [15:0] rate_cnt;
      logic        tick;
   } sdb_top_s;
endpackage

// File: sdb_fifo.sv
`timescale 1ns/1ps
module sdb_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   import sdb_pkg::*;
   localparam int AW = $clog2(DEPTH);

   // Pointers, fill level and registered flags
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
      logic          not_full;
      logic          empty;
   } sdb_fifo_s;

   sdb_fifo_s        st;        // Current state
   sdb_fifo_s        next_st;   // Next state
   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic             push;      // Word accepted
   logic             pop;       // Word delivered

   // ----------------------------------------
   // Handshakes
   // ----------------------------------------
   assign push          = in_valid_in && st.not_full;
   assign pop           = out_ready_in && !st.empty;
   assign in_ready_out  = st.not_full;
   assign out_valid_out = !st.empty;
   assign out_data_out  = mem[st.rd_ptr];

   // Next pointers and flags; flags are registered so ready is a flop
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_st.count = st.count + 1'b1;
      end else if (pop && !push) begin
         next_st.count = st.count - 1'b1;
      end
      next_st.not_full = (next_st.count != (AW+1)'(DEPTH));
      next_st.empty = (next_st.count == '0);
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st       <= '0;
         st.empty <= 1'b1;
         st.not_full <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Storage carries no reset; contents are qualified by empty
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem[st.wr_ptr] <= in_data_in;
      end
   end
endmodule

// File: sdb_core.sv
// Behaviour
// - Receive buffer read-only, holds last character's low byte
// - Receive byte and ninth bit queued in a FIFO_DEPTH-deep FIFO ahead of the holding register
// - Transmit byte and ninth bit held in one register; a new write overwrites it
// - Low divider write restarts rate counter
// - High divider write restarts rate counter
// - High byte ignored unless wide divider selected
// - Divider is high and low bytes concatenated
// - Async narrow slow: clock over 64(n+1)
// - Async narrow fast or wide slow: 16(n+1)
// - Synchronous mode: clock over 4(n+1)
// - Wide select: 16-bit set, 8-bit clear
// - Fast select ignored in synchronous mode
// - Mode select picks synchronous or asynchronous
`timescale 1ns/1ps
`include "sdb_params.svh"
module sdb_core #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_b_in,
   input  wire sdb_pkg::sdb_addr_t addr_in,
   input  wire sdb_pkg::sdb_byte_t wr_data_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output sdb_pkg::sdb_byte_t     rd_data_out,
   input  wire logic              rx_valid_in,
   input  wire logic [7:0]        rx_data_in,
   input  wire logic              rx_ninth_in,
   output logic                   rx_ready_out,
   input  wire logic              tx_take_in,
   output logic                   tx_valid_out,
   output logic [7:0]             tx_data_out,
   output logic                   tx_ninth_out,
   output logic                   rate_tick_out,
   output logic                   sync_mode_out
);
   import sdb_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   sdb_top_s    st;          // Current state
   sdb_top_s    next_st;     // Next state
   logic        f_valid;     // Receive FIFO holds a character
   logic [8:0]  f_data;      // Receive FIFO head, ninth bit on top
   logic        f_pop;       // Move FIFO head into the receive buffer
   logic        rd_rx;       // Software reads the receive buffer
   logic        restart;     // Divider write restarts the generator
   logic [15:0] eff_div;     // Divider in force
   logic [6:0]  presc;       // Prescale in force

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Divider in force for the given bytes and width select
   function automatic logic [15:0] f_divider(input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic       wide);
      if (wide) begin
         f_divider = {hi, lo};
      end else begin
         f_divider = {8'h00, lo};
      end
   endfunction

   // Prescale for the mode, speed and width selects
   function automatic logic [6:0] f_prescale(input logic sync,
                                             input logic fast,
                                             input logic wide);
      if (sync) begin
         f_prescale = `SDB_PRESC_SYNC;
      end else if (wide && fast) begin
         f_prescale = `SDB_PRESC_SYNC;
      end else if (wide || fast) begin
         f_prescale = `SDB_PRESC_FAST;
      end else begin
         f_prescale = `SDB_PRESC_SLOW;
      end
   endfunction

   // ----------------------------------------
   // Receive FIFO
   // ----------------------------------------
   // Deep buffering ahead of the holding register; the shifter stalls on rx_ready_out
   sdb_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk_in   (core_clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (rx_valid_in),
      .in_data_in    ({rx_ninth_in, rx_data_in}),
      .in_ready_out  (rx_ready_out),
      .out_valid_out (f_valid),
      .out_data_out  (f_data),
      .out_ready_in  (f_pop)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign rd_rx   = rd_in && (addr_in == `SDB_OFS_RX_BUF);
   assign restart = wr_in && ((addr_in == `SDB_OFS_DIV_LOW) || (addr_in == `SDB_OFS_DIV_HIGH));
   // Holding register refills when empty or emptied by this read
   assign f_pop   = f_valid && (!st.rx_full || rd_rx);
   assign eff_div = f_divider(st.div_low, st.div_high, st.wide_div);
   assign presc   = f_prescale(st.sync_mode, st.fast_rate, st.wide_div);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // Register writes; the receive buffer has no write path
      if (wr_in) begin
         case (addr_in)
            `SDB_OFS_TX_BUF: begin
               next_st.tx_last = wr_data_in;
            end
            `SDB_OFS_DIV_LOW: begin
               next_st.div_low = wr_data_in;
            end
            `SDB_OFS_DIV_HIGH: begin
               next_st.div_high = wr_data_in;
            end
            `SDB_OFS_CTRL: begin
               next_st.sync_mode = wr_data_in[`SDB_CTRL_SYNC];
               next_st.fast_rate = wr_data_in[`SDB_CTRL_FAST];
               next_st.wide_div  = wr_data_in[`SDB_CTRL_WIDE];
               next_st.tx9_stage = wr_data_in[`SDB_CTRL_TX9];
            end
            default: begin
               // Read-only or unmapped: ignored
            end
         endcase
      end

      // Read data, answered one cycle later; unmapped reads as zero
      next_st.rd_data = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `SDB_OFS_RX_BUF: begin
               next_st.rd_data = st.rx_byte;
            end
            `SDB_OFS_TX_BUF: begin
               next_st.rd_data = st.tx_last;
            end
            `SDB_OFS_DIV_LOW: begin
               next_st.rd_data = st.div_low;
            end
            `SDB_OFS_DIV_HIGH: begin
               next_st.rd_data = st.div_high;
            end
            `SDB_OFS_CTRL: begin
               next_st.rd_data[`SDB_CTRL_SYNC] = st.sync_mode;
               next_st.rd_data[`SDB_CTRL_FAST] = st.fast_rate;
               next_st.rd_data[`SDB_CTRL_WIDE] = st.wide_div;
               next_st.rd_data[`SDB_CTRL_TX9]  = st.tx9_stage;
            end
            `SDB_OFS_STATUS: begin
               next_st.rd_data[`SDB_STAT_RX9]       = st.rx_ninth;
               next_st.rd_data[`SDB_STAT_RX_FULL]   = st.rx_full;
               next_st.rd_data[`SDB_STAT_TX_FULL]   = st.tx_valid;
               next_st.rd_data[`SDB_STAT_FIFO_DATA] = f_valid;
            end
            default: begin
               next_st.rd_data = 8'h00;
            end
         endcase
      end

      // Receive holding register; byte and ninth bit move together
      if (f_pop) begin
         next_st.rx_byte  = f_data[7:0];
         next_st.rx_ninth = f_data[8];
         next_st.rx_full  = 1'b1;
      end else if (rd_rx) begin
         // Data stays readable; only the full flag drops
         next_st.rx_full = 1'b0;
      end

      // Transmit holding register; the take clears, a write in the same cycle wins
      if (tx_take_in) begin
         next_st.tx_valid = 1'b0;
      end
      if (wr_in && (addr_in == `SDB_OFS_TX_BUF)) begin
         next_st.tx_data  = wr_data_in;
         next_st.tx_ninth = st.tx9_stage;
         next_st.tx_valid = 1'b1;
      end

      // Rate generator
      next_st.tick = 1'b0;
      if (restart) begin
         // Counter restarts from the new divider
         next_st.pre_cnt  = 7'h00;
         next_st.rate_cnt = f_divider(next_st.div_low, next_st.div_high, st.wide_div);
      end else if (st.pre_cnt >= presc - 7'h01) begin
         // Compare by >= so a mode change mid-count cannot overrun
         next_st.pre_cnt = 7'h00;
         if (st.rate_cnt == 16'h0000) begin
            next_st.rate_cnt = eff_div;
            next_st.tick     = 1'b1;
         end else begin
            next_st.rate_cnt = st.rate_cnt - 16'h0001;
         end
      end else begin
         next_st.pre_cnt = st.pre_cnt + 7'h01;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st          <= '0;
         st.rx_byte  <= `SDB_RST_BYTE;
         st.tx_last  <= `SDB_RST_BYTE;
         st.div_low  <= `SDB_RST_BYTE;
         st.div_high <= `SDB_RST_BYTE;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs, each straight from a flop
   // ----------------------------------------
   assign rd_data_out   = st.rd_data;
   assign tx_valid_out  = st.tx_valid;
   assign tx_data_out   = st.tx_data;
   assign tx_ninth_out  = st.tx_ninth;
   assign rate_tick_out = st.tick;
   assign sync_mode_out = st.sync_mode;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_rx_readonly;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_in && addr_in == `SDB_OFS_RX_BUF && !f_pop) |=> $stable(st.rx_byte);
   endproperty
   a_rx_readonly: assert property (p_rx_readonly) else $error("receive buffer changed by a write");

   property p_rx_read;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      rd_rx |=> (rd_data_out == $past(st.rx_byte));
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("receive read returned wrong byte");

   property p_rx_hold;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (st.rx_full && !rd_rx && rx_valid_in) |=> ($stable(st.rx_byte) && $stable(st.rx_ninth));
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("held character overwritten");

   property p_tx_load;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_in && addr_in == `SDB_OFS_TX_BUF)
         |=> (tx_valid_out && tx_data_out == $past(wr_data_in) && tx_ninth_out == $past(st.tx9_stage));
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("transmit write not held");

   property p_restart_low;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_in && addr_in == `SDB_OFS_DIV_LOW) |=> (st.pre_cnt == 7'h00 && st.rate_cnt == eff_div && !rate_tick_out);
   endproperty
   a_restart_low: assert property (p_restart_low) else $error("low write did not restart");

   property p_restart_high;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_in && addr_in == `SDB_OFS_DIV_HIGH) |=> (st.pre_cnt == 7'h00 && st.rate_cnt == eff_div);
   endproperty
   a_restart_high: assert property (p_restart_high) else $error("high write did not restart");

   property p_narrow;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      !st.wide_div |-> (eff_div == {8'h00, st.div_low});
   endproperty
   a_narrow: assert property (p_narrow) else $error("high byte used in narrow mode");

   property p_wide;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      st.wide_div |-> (eff_div == {st.div_high, st.div_low});
   endproperty
   a_wide: assert property (p_wide) else $error("wide divider not concatenated");

   property p_slow;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!st.sync_mode && !st.wide_div && !st.fast_rate) |-> (presc == 7'h40);
   endproperty
   a_slow: assert property (p_slow) else $error("slow prescale not 64");

   property p_mid;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!st.sync_mode && (st.wide_div ^ st.fast_rate)) |-> (presc == 7'h10);
   endproperty
   a_mid: assert property (p_mid) else $error("prescale not 16");

   property p_sync;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (st.sync_mode || (st.wide_div && st.fast_rate)) |-> (presc == 7'h04);
   endproperty
   a_sync: assert property (p_sync) else $error("prescale not 4");

   property p_reload;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (rate_tick_out && !$past(wr_in)) |-> (st.rate_cnt == eff_div && st.pre_cnt == 7'h00);
   endproperty
   a_reload: assert property (p_reload) else $error("tick without reload");

   property p_tick_gap;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      rate_tick_out |=> !rate_tick_out [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than four cycles");

   property p_tx_take;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (tx_take_in && !(wr_in && addr_in == `SDB_OFS_TX_BUF)) |=> !tx_valid_out;
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("taken character still held");

   property p_rx_fill;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      f_pop |=> (st.rx_full && {st.rx_ninth, st.rx_byte} == $past(f_data));
   endproperty
   a_rx_fill: assert property (p_rx_fill) else $error("queued character not moved to holding");

   property p_rx9_read;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (rd_in && addr_in == `SDB_OFS_STATUS) |=> (rd_data_out[`SDB_STAT_RX9] == $past(st.rx_ninth));
   endproperty
   a_rx9_read: assert property (p_rx9_read) else $error("ninth received bit misreported");

   // Between ticks the counter must step down once per prescale expiry
   property p_count_down;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!restart && st.pre_cnt >= presc - 7'h01 && st.rate_cnt != 16'h0000)
         |=> (st.rate_cnt == $past(st.rate_cnt) - 16'h0001 && !rate_tick_out);
   endproperty
   a_count_down: assert property (p_count_down) else $error("rate counter skipped a step");
endmodule

// File: sdb_shifter_model.sv
`timescale 1ns/1ps
// Far-side shifter model: offers received characters and takes held
// transmit characters, stalling the take while take_en_in is low
module sdb_shifter_model (
   input  wire logic       core_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       rx_ready_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_ninth_in,
   input  wire logic       take_en_in,
   output logic            rx_valid_out,
   output logic [7:0]      rx_data_out,
   output logic            rx_ninth_out,
   output logic            tx_take_out,
   output logic [8:0]      taken_out
);
   initial begin
      rx_valid_out = 1'b0;
      rx_data_out  = 8'h00;
      rx_ninth_out = 1'b0;
   end

   // ------------------------------
   // Receive side
   // ------------------------------
   // Hold the offer until the block is ready; afterwards the lines show the
   // inverse so a stale value can never be mistaken for a fresh one
   task automatic send(input logic [8:0] ch);
      @(posedge core_clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out  <= ch[7:0];
      rx_ninth_out <= ch[8];
      do @(posedge core_clk_in); while (rx_ready_in !== 1'b1);
      rx_valid_out <= 1'b0;
      rx_data_out  <= ~ch[7:0];
      rx_ninth_out <= ~ch[8];
   endtask

   // ------------------------------
   // Transmit side
   // ------------------------------
   // One take pulse per held character; the character is recorded at the
   // edge where the pulse is seen
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_take_out <= 1'b0;
         taken_out   <= 9'h000;
      end else begin
         tx_take_out <= take_en_in && tx_valid_in && !tx_take_out;
         if (tx_take_out) begin
            taken_out <= {tx_ninth_in, tx_data_in};
         end
      end
   end
endmodule

// File: sdb_core_test.sv
`timescale 1ns/1ps
`include "sdb_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sdb_core_test;
   import sdb_pkg::*;
   logic       core_clk_in, rst_b_in, wr_in, rd_in, rx_valid_in, rx_ninth_in, rx_ready_out;
   sdb_addr_t  addr_in;
   sdb_byte_t  wr_data_in, rd_data_out, d;
   logic [7:0] rx_data_in, tx_data_out;
   logic       tx_take_in, tx_valid_out, tx_ninth_out, rate_tick_out, sync_mode_out, take_en;
   logic [8:0] taken;
   int         errors = 0;
   int         compares = 0;
   int         k, p;

   sdb_core #(.FIFO_DEPTH(32)) i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_ninth_in(rx_ninth_in),
      .rx_ready_out(rx_ready_out), .tx_take_in(tx_take_in), .tx_valid_out(tx_valid_out),
      .tx_data_out(tx_data_out), .tx_ninth_out(tx_ninth_out), .rate_tick_out(rate_tick_out),
      .sync_mode_out(sync_mode_out));
   sdb_shifter_model i_far (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .rx_ready_in(rx_ready_out),
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ninth_in(tx_ninth_out),
      .take_en_in(take_en), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
      .rx_ninth_out(rx_ninth_in), .tx_take_out(tx_take_in), .taken_out(taken));

   // ------------------------------
   // Clock, bus tasks, helpers
   // ------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   task automatic wr(input sdb_addr_t a, input sdb_byte_t v);
      @(posedge core_clk_in);
      addr_in <= a; wr_data_in <= v; wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, sampled mid-cycle
   task automatic rd(input sdb_addr_t a, output sdb_byte_t v);
      @(posedge core_clk_in);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      @(negedge core_clk_in);
      v = rd_data_out;
   endtask

   function automatic sdb_byte_t stat(logic r9, logic rf, logic tf, logic ff);
      stat = 8'h00;
      stat[`SDB_STAT_RX9] = r9; stat[`SDB_STAT_RX_FULL] = rf;
      stat[`SDB_STAT_TX_FULL] = tf; stat[`SDB_STAT_FIFO_DATA] = ff;
   endfunction

   // Cycles until the next rate tick, bounded so a dead generator cannot hang
   task automatic to_tick(output int n);
      n = 0;
      do begin @(negedge core_clk_in); n++; end while (rate_tick_out !== 1'b1 && n < 9000);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], d);
         `CHK(d, `SDB_RST_BYTE)
      end
      `CHK(rx_ready_out, 1'b1)
      $display("test reset done");
   endtask

   // Second character waits behind the first; a write to the receive index is ignored
   task automatic t_rx_double;
      i_far.send(9'h1c3); wait_cyc(4);
      i_far.send(9'h05a); wait_cyc(4);
      rd(`SDB_OFS_STATUS, d); `CHK(d, stat(1'b1, 1'b1, 1'b0, 1'b1))
      wr(`SDB_OFS_RX_BUF, 8'hff);
      rd(`SDB_OFS_RX_BUF, d); `CHK(d, 8'hc3)
      wait_cyc(4);
      rd(`SDB_OFS_STATUS, d); `CHK(d, stat(1'b0, 1'b1, 1'b0, 1'b0))
      rd(`SDB_OFS_RX_BUF, d); `CHK(d, 8'h5a)
      wait_cyc(4);
      rd(`SDB_OFS_STATUS, d); `CHK(d, stat(1'b0, 1'b0, 1'b0, 1'b0))
      $display("test rx double done");
   endtask

   // Fill 32 queued plus one held until refused, then drain in order
   task automatic t_rx_fill;
      for (int i = 0; i < 33; i++) i_far.send({i[0], i[7:0]});
      wait_cyc(4);
      `CHK(rx_ready_out, 1'b0)
      for (int i = 0; i < 33; i++) begin
         rd(`SDB_OFS_RX_BUF, d); `CHK(d, i[7:0])
         wait_cyc(4);
      end
      rd(`SDB_OFS_STATUS, d); `CHK(d, stat(1'b0, 1'b0, 1'b0, 1'b0))
      `CHK(rx_ready_out, 1'b1)
      $display("test rx fill done");
   endtask

   task automatic t_tx;
      take_en <= 1'b0;
      wr(`SDB_OFS_CTRL, 8'h08); wr(`SDB_OFS_TX_BUF, 8'ha5);
      @(negedge core_clk_in);
      `CHK({tx_valid_out, tx_ninth_out, tx_data_out}, 10'h3a5)
      rd(`SDB_OFS_TX_BUF, d); `CHK(d, 8'ha5)
      rd(`SDB_OFS_STATUS, d); `CHK(d, stat(1'b0, 1'b0, 1'b1, 1'b0))
      wr(`SDB_OFS_CTRL, 8'h00); wr(`SDB_OFS_TX_BUF, 8'h3c);
      take_en <= 1'b1; wait_cyc(4);
      `CHK(taken, 9'h03c)
      `CHK(tx_valid_out, 1'b0)
      wr(`SDB_OFS_CTRL, 8'h08); wr(`SDB_OFS_TX_BUF, 8'h11); wait_cyc(3);
      `CHK(taken, 9'h111)
      wr(`SDB_OFS_TX_BUF, 8'h22); wait_cyc(3);
      `CHK(taken, 9'h122)
      $display("test tx done");
   endtask

   // Every mode, width and speed combination; high byte is written in all
   task automatic t_rate;
      logic [6:0]  pr;
      logic [15:0] n;
      for (int m = 0; m < 8; m++) begin
         pr = m[0] ? 7'h04 : (m[1] && m[2]) ? 7'h04 : (m[1] || m[2]) ? 7'h10 : 7'h40;
         n  = m[2] ? 16'h0102 : 16'h0002;
         p  = int'(pr) * (int'(n) + 1);
         wr(`SDB_OFS_CTRL, {5'h00, m[2:0]});
         wr(`SDB_OFS_DIV_LOW, 8'h02); wr(`SDB_OFS_DIV_HIGH, 8'h01);
         `CHK(sync_mode_out, m[0])
         to_tick(k); `CHK(k >= p - 1 && k <= p + 1, 1'b1)
         to_tick(k); `CHK(k, p)
         rd(`SDB_OFS_CTRL, d); `CHK(d, 8'(m[2:0]))
      end
      $display("test rate done");
   endtask

   // Mid-period divider writes must start a full period afresh
   task automatic t_restart;
      wr(`SDB_OFS_CTRL, 8'h00); wr(`SDB_OFS_DIV_LOW, 8'h02);
      to_tick(k); wait_cyc(96); wr(`SDB_OFS_DIV_LOW, 8'h02);
      to_tick(k); `CHK(k >= 191 && k <= 193, 1'b1)
      wait_cyc(96); wr(`SDB_OFS_DIV_HIGH, 8'h07);
      to_tick(k); `CHK(k >= 191 && k <= 193, 1'b1)
      rd(`SDB_OFS_DIV_HIGH, d); `CHK(d, 8'h07)
      $display("test restart done");
   endtask

   // ------------------------------
   // Verdict and main sequence
   // ------------------------------
   task automatic complete_run;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog: about two and a half times the expected run length
   initial begin
      #(40000 * 5);
      errors++;
      complete_run();
   end

   initial begin
      rst_b_in = 1'b0; addr_in = 3'h0; wr_data_in = 8'h00; wr_in = 1'b0; rd_in = 1'b0; take_en = 1'b0;
      repeat (10) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      t_reset(); t_rx_double(); t_rx_fill(); t_tx(); t_rate(); t_restart();
      complete_run();
   end
endmodule
